// ### plcc_ctrl.sv
// Single-wire pulse-count control: edge counting, latch and off timeouts,
// pump mode stepping, auto-disable, regulator enable and thermal shutdown.
// Assumes asynchronous pins from analog comparators and the host line.
`timescale 1ns/1ps
`include "plcc_regs.svh"

// Behaviour
// - Count rising edges on the control line into sixteen current states.
// - Codes 1-12 follow a near-linear scale in steps of about 1.6 mA, codes 13-16 a low-current scale.
// - Codes map to 20,18.4,...,2.0,1.0,0.5,0.10,0.05 mA per channel.
// - Codes 13-16 also engage the reduced quiescent-current mode.
// - Line high for the latch timeout makes the counted code active.
// - Latching clears the edge counter to zero.
// - Line low beyond the off timeout enters shutdown, pump and sinks off.
// - Shutdown clears the data register to zero.
// - Edges from above 1MHz down to 15kHz are accepted.
// - Line activity alone enables the pump and sets sink currents.
// - Pump steps 1X to 1.5X to 2X each time an enabled sink nears dropout while none was before.
// - An unconnected unused sink forces 2X-only pump operation.
// - After startup, test each sink and disable those failing the threshold.
// - One regulator enable drives both regulators, apart from the line.
// - Over-temperature shuts down the pump and both regulators.
// - Pump switching runs from an internal clock of about 1MHz.
module plcc_ctrl
    import plcc_pkg::*;
#(
    parameter int LATCH_CYCLES   = `PLCC_LATCH_CYC,
    parameter int OFF_CYCLES     = `PLCC_OFF_CYC,
    parameter int STARTUP_CYCLES = `PLCC_STARTUP_CYC,
    parameter int TEST_CYCLES    = `PLCC_TEST_CYC,
    parameter int PUMP_DIV       = `PLCC_PUMP_HZ_DIV,
    parameter int CHANNELS       = 4
) (
    input  wire logic                clock,
    input  wire logic                rst_n,
    input  wire logic                enableSet,
    input  wire logic                regulatorEnable,
    input  wire logic                overTemp,
    input  wire logic [CHANNELS-1:0] sinkNearDropout,
    input  wire logic [CHANNELS-1:0] sinkOpen,
    input  wire logic [CHANNELS-1:0] sinkBelowThreshold,
    output logic                     pumpEnable,
    output plcc_pump_type            pumpMode,
    output logic                     pumpClockEn,
    output logic [CHANNELS-1:0]      sinkEnable,
    output logic [CHANNELS-1:0]      sinkTestCurrent,
    output logic [15:0]              sinkCurrentUa,
    output logic                     lowQuiescent,
    output logic                     regulatorOn,
    output logic [4:0]               activeCode
);
    // Current in units of 10 uA so every setting is a whole count
    function automatic logic [15:0] codeToCurrent(input logic [4:0] code);
        unique case (code)
            5'h01:   codeToCurrent = 16'h07d0;
            5'h02:   codeToCurrent = 16'h0730;
            5'h03:   codeToCurrent = 16'h0690;
            5'h04:   codeToCurrent = 16'h05f0;
            5'h05:   codeToCurrent = 16'h0546;
            5'h06:   codeToCurrent = 16'h04a6;
            5'h07:   codeToCurrent = 16'h03e8;
            5'h08:   codeToCurrent = 16'h0348;
            5'h09:   codeToCurrent = 16'h02a8;
            5'h0a:   codeToCurrent = 16'h0208;
            5'h0b:   codeToCurrent = 16'h015e;
            5'h0c:   codeToCurrent = 16'h00c8;
            5'h0d:   codeToCurrent = 16'h0064;
            5'h0e:   codeToCurrent = 16'h0032;
            5'h0f:   codeToCurrent = 16'h000a;
            5'h10:   codeToCurrent = 16'h0005;
            default: codeToCurrent = 16'h0000;
        endcase
    endfunction

    function automatic logic isLowScale(input logic [4:0] code);
        isLowScale = (code > `PLCC_CODE_LOG_LAST) && (code <= `PLCC_CODE_MAX);
    endfunction

    logic                lineLevel;
    logic                lineLevelPrev_q;
    logic                ovtLevel;
    logic                regLevel;
    logic [CHANNELS-1:0] dropLevel;
    logic [CHANNELS-1:0] openLevel;
    logic [CHANNELS-1:0] belowLevel;

    plcc_sync3 uLine (
        .clock    (clock),
        .rst_n    (rst_n),
        .rawPin   (enableSet),
        .settled  (lineLevel)
    );
    plcc_sync3 uOvt (
        .clock    (clock),
        .rst_n    (rst_n),
        .rawPin   (overTemp),
        .settled  (ovtLevel)
    );
    plcc_sync3 uReg (
        .clock    (clock),
        .rst_n    (rst_n),
        .rawPin   (regulatorEnable),
        .settled  (regLevel)
    );

    for (genvar i = 0; i < CHANNELS; i++) begin : gSink
        plcc_sync3 uDrop (
            .clock    (clock),
            .rst_n    (rst_n),
            .rawPin   (sinkNearDropout[i]),
            .settled  (dropLevel[i])
        );
        plcc_sync3 uOpen (
            .clock    (clock),
            .rst_n    (rst_n),
            .rawPin   (sinkOpen[i]),
            .settled  (openLevel[i])
        );
        plcc_sync3 uBelow (
            .clock    (clock),
            .rst_n    (rst_n),
            .rawPin   (sinkBelowThreshold[i]),
            .settled  (belowLevel[i])
        );
    end

    logic        riseEvt;
    logic [4:0]  edgeCount_q;
    logic [31:0] highCnt_q;
    logic [31:0] lowCnt_q;
    logic        latchEvt;
    logic        offEvt;
    logic [4:0]  code_q;
    plcc_state_type state_q;
    logic [31:0] phaseCnt_q;
    logic [CHANNELS-1:0] chanOk_q;
    logic        dropPrev_q;
    logic        dropAny;

    // Sync stage filters glitches but at 40 MHz keeps >1MHz edges
    assign riseEvt  = lineLevel && !lineLevelPrev_q;
    assign latchEvt = lineLevel && (highCnt_q == 32'(LATCH_CYCLES - 1));
    assign offEvt   = !lineLevel && (lowCnt_q == 32'(OFF_CYCLES - 1));
    assign dropAny  = |(dropLevel & chanOk_q);

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lineLevelPrev_q <= 1'b0;
        end else begin
            lineLevelPrev_q <= lineLevel;
        end
    end

    // High and low timers restart on every change of the line
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            highCnt_q <= 32'h0;
            lowCnt_q  <= 32'h0;
        end else if (lineLevel) begin
            lowCnt_q <= 32'h0;
            if (riseEvt) begin
                highCnt_q <= 32'h0;
            end else if (highCnt_q < 32'(LATCH_CYCLES)) begin
                highCnt_q <= highCnt_q + 32'h1;
            end
        end else begin
            highCnt_q <= 32'h0;
            if (lowCnt_q < 32'(OFF_CYCLES)) begin
                lowCnt_q <= lowCnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            edgeCount_q <= `PLCC_CODE_RESET;
        end else if (offEvt || latchEvt) begin
            edgeCount_q <= `PLCC_CODE_RESET;
        end else if (riseEvt && edgeCount_q != `PLCC_CODE_MAX) begin
            edgeCount_q <= edgeCount_q + 5'h01;
        end
    end

    // A latch with no counted edges keeps the previous code
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            code_q <= `PLCC_CODE_RESET;
        end else if (offEvt) begin
            code_q <= `PLCC_CODE_RESET;
        end else if (latchEvt && edgeCount_q != `PLCC_CODE_RESET) begin
            code_q <= edgeCount_q;
        end
    end

    // Startup then per-channel test, then run
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= ST_OFF;
            phaseCnt_q <= 32'h0;
            chanOk_q   <= '0;
        end else if (offEvt || ovtLevel) begin
            state_q    <= ST_OFF;
            phaseCnt_q <= 32'h0;
            chanOk_q   <= '0;
        end else begin
            unique case (state_q)
                ST_OFF: begin
                    if (code_q != `PLCC_CODE_RESET) begin
                        state_q    <= ST_START;
                        phaseCnt_q <= 32'h0;
                    end
                end
                ST_START: begin
                    phaseCnt_q <= phaseCnt_q + 32'h1;
                    if (phaseCnt_q == 32'(STARTUP_CYCLES - 1)) begin
                        state_q    <= ST_TEST;
                        phaseCnt_q <= 32'h0;
                    end
                end
                ST_TEST: begin
                    phaseCnt_q <= phaseCnt_q + 32'h1;
                    if (phaseCnt_q == 32'(TEST_CYCLES - 1)) begin
                        state_q  <= ST_RUN;
                        chanOk_q <= belowLevel;
                    end
                end
                ST_RUN: begin
                    phaseCnt_q <= 32'h0;
                end
            endcase
        end
    end

    // Pump mode only steps upward; a fresh start returns to 1X
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pumpMode   <= PUMP_1X;
            dropPrev_q <= 1'b0;
        end else if (state_q != ST_RUN) begin
            pumpMode   <= PUMP_1X;
            dropPrev_q <= 1'b0;
        end else begin
            dropPrev_q <= dropAny;
            if (|openLevel) begin
                pumpMode <= PUMP_2X;
            end else if (dropAny && !dropPrev_q) begin
                unique case (pumpMode)
                    PUMP_1X:   pumpMode <= PUMP_1P5X;
                    PUMP_1P5X: pumpMode <= PUMP_2X;
                    PUMP_2X:   pumpMode <= PUMP_2X;
                    default:   pumpMode <= PUMP_2X;
                endcase
            end
        end
    end

    // Divider for the pump switching enable, about 1MHz
    logic [7:0] divCnt_q;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            divCnt_q    <= 8'h00;
            pumpClockEn <= 1'b0;
        end else if (divCnt_q == 8'(PUMP_DIV - 1)) begin
            divCnt_q    <= 8'h00;
            pumpClockEn <= (state_q != ST_OFF) && (pumpMode != PUMP_1X);
        end else begin
            divCnt_q    <= divCnt_q + 8'h01;
            pumpClockEn <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pumpEnable      <= 1'b0;
            sinkEnable      <= '0;
            sinkTestCurrent <= '0;
            sinkCurrentUa   <= 16'h0000;
            lowQuiescent    <= 1'b0;
            activeCode      <= `PLCC_CODE_RESET;
        end else begin
            pumpEnable      <= (state_q != ST_OFF) && !offEvt && !ovtLevel;
            sinkTestCurrent <= (state_q == ST_TEST) ? '1 : '0;
            sinkEnable      <= (state_q == ST_RUN && !offEvt && !ovtLevel) ? chanOk_q : '0;
            sinkCurrentUa   <= codeToCurrent(code_q);
            lowQuiescent    <= isLowScale(code_q);
            activeCode      <= code_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            regulatorOn <= 1'b0;
        end else begin
            regulatorOn <= regLevel && !ovtLevel;
        end
    end

    chk_count_sat: assert property (@(posedge clock) disable iff (!rst_n)
        edgeCount_q <= `PLCC_CODE_MAX)
        else $error("edge count above sixteen");
    chk_count_step: assert property (@(posedge clock) disable iff (!rst_n)
        (riseEvt && !offEvt && !latchEvt && edgeCount_q < `PLCC_CODE_MAX)
        |=> edgeCount_q == $past(edgeCount_q) + 5'h01)
        else $error("rising edge not counted");
    chk_latch_code: assert property (@(posedge clock) disable iff (!rst_n)
        (latchEvt && edgeCount_q != 5'h00) |=> code_q == $past(edgeCount_q))
        else $error("latched code wrong");
    chk_latch_clear: assert property (@(posedge clock) disable iff (!rst_n)
        latchEvt |=> edgeCount_q == 5'h00)
        else $error("count not cleared on latch");
    chk_off_clear: assert property (@(posedge clock) disable iff (!rst_n)
        offEvt |=> code_q == 5'h00 && edgeCount_q == 5'h00)
        else $error("shutdown left data");
    chk_off_pump: assert property (@(posedge clock) disable iff (!rst_n)
        offEvt |=> !pumpEnable && sinkEnable == '0)
        else $error("shutdown left pump on");
    chk_low_mode: assert property (@(posedge clock) disable iff (!rst_n)
        ##1 lowQuiescent == ($past(code_q) > 5'h0c))
        else $error("low quiescent mode mismatch");
    chk_ovt_off: assert property (@(posedge clock) disable iff (!rst_n)
        ovtLevel |=> !regulatorOn && !pumpEnable)
        else $error("thermal shutdown ignored");
    chk_pump_step: assert property (@(posedge clock) disable iff (!rst_n)
        (pumpMode == PUMP_2X) |=> (pumpMode == PUMP_2X) || $past(state_q) != ST_RUN)
        else $error("pump stepped down while running");
    chk_current_map: assert property (@(posedge clock) disable iff (!rst_n)
        (code_q == 5'h01) |=> sinkCurrentUa == 16'h07d0)
        else $error("code one current wrong");
    chk_reg_follow: assert property (@(posedge clock) disable iff (!rst_n)
        (regLevel && !ovtLevel) |=> regulatorOn)
        else $error("regulators not enabled");
    chk_test_drive: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == ST_TEST) |=> sinkTestCurrent == '1)
        else $error("test current not forced");
    chk_open_2x: assert property (@(posedge clock) disable iff (!rst_n)
        (state_q == ST_RUN && |openLevel) |=> pumpMode == PUMP_2X)
        else $error("open sink did not force double mode");

    cov_latch:    cover property (@(posedge clock) disable iff (!rst_n) latchEvt);
    cov_shutdown: cover property (@(posedge clock) disable iff (!rst_n) offEvt);
    cov_pump_2x:  cover property (@(posedge clock) disable iff (!rst_n) pumpMode == PUMP_2X);
    cov_low_code: cover property (@(posedge clock) disable iff (!rst_n) lowQuiescent);
endmodule

// ### plcc_regs.svh
// Timing counts and code constants for the pulse-count current control block.
// Assumes a 40 MHz system clock.
`ifndef PLCC_REGS_SVH
`define PLCC_REGS_SVH

`define PLCC_CLK_MHZ         40
`define PLCC_LATCH_US        500
`define PLCC_LATCH_CYC       (`PLCC_LATCH_US * `PLCC_CLK_MHZ)
`define PLCC_OFF_US          500
`define PLCC_OFF_CYC         (`PLCC_OFF_US * `PLCC_CLK_MHZ)
`define PLCC_PUMP_HZ_DIV     40
`define PLCC_STARTUP_US      100
`define PLCC_STARTUP_CYC     (`PLCC_STARTUP_US * `PLCC_CLK_MHZ)
`define PLCC_TEST_US         20
`define PLCC_TEST_CYC        (`PLCC_TEST_US * `PLCC_CLK_MHZ)
`define PLCC_CODE_MAX        5'h10
`define PLCC_CODE_LOG_LAST   5'h0c
`define PLCC_CODE_RESET      5'h00
`define PLCC_CURR_20MA       16'h4e20

`endif

// ### plcc_pkg.sv
// Types shared by the pulse-count current control block.
// Assumes plcc_regs.svh defines the numeric constants.
package plcc_pkg;
    typedef enum logic [1:0] {
        PUMP_1X,
        PUMP_1P5X,
        PUMP_2X
    } plcc_pump_type;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_START,
        ST_TEST,
        ST_RUN
    } plcc_state_type;

    typedef struct packed {
        logic [3:0]  sinkOn;
        logic [15:0] currentUa;
        logic        lowQuiescent;
    } plcc_sink_type;
endpackage

// ### plcc_sync3.sv
// Three-stage synchroniser with agreement filter for one asynchronous pin.
// Assumes one system clock; output changes when stages two and three agree.
`timescale 1ns/1ps
module plcc_sync3
    import plcc_pkg::*;
(
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic rawPin,
    output logic      settled
);
    logic s1_q;
    logic s2_q;
    logic s3_q;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end else begin
            s1_q <= rawPin;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            settled <= 1'b0;
        end else if (s2_q == s3_q) begin
            settled <= s3_q;
        end
    end
endmodule

// ### plcc_host_model.sv
// Host controller model that drives the single control line.
// Assumes the line is sampled on the rising edge of clock.
`timescale 1ns/1ps
module plcc_host_model
    import plcc_pkg::*;
(
    input  wire logic clock,
    output logic      line
);
    initial line = 1'b0;

    // Low phase then high phase per edge, line left high after the last one
    task automatic sendCode(input int n, input int half);
        for (int i = 0; i < n; i++) begin
            @(negedge clock) line <= 1'b0;
            repeat (half) @(negedge clock);
            line <= 1'b1;
            repeat (half - 1) @(negedge clock);
        end
    endtask

    task automatic setLine(input logic v);
        @(negedge clock) line <= v;
    endtask
endmodule

// ### test_pulse_count_led_current_control.sv
// Self-checking bench for the pulse-count current control block.
// Assumes shortened timeout parameters; the host model drives the line.
`timescale 1ns/1ps
module test_pulse_count_led_current_control
    import plcc_pkg::*;
();
    localparam int LATCH = 50;
    localparam int OFF   = 50;
    localparam int START = 20;
    localparam int TEST  = 10;
    localparam int DIV   = 4;

    typedef struct packed {
        logic [4:0]  code;
        logic [7:0]  half;
        logic [15:0] cur;
        logic        lowQ;
    } plcc_row_type;

    // Edge spacing varies per row to cover fast and slow hosts
    plcc_row_type rows [16] = '{
        '{5'h01, 8'h04, 16'h07d0, 1'b0}, '{5'h02, 8'h09, 16'h0730, 1'b0},
        '{5'h03, 8'h0e, 16'h0690, 1'b0}, '{5'h04, 8'h04, 16'h05f0, 1'b0},
        '{5'h05, 8'h09, 16'h0546, 1'b0}, '{5'h06, 8'h0e, 16'h04a6, 1'b0},
        '{5'h07, 8'h04, 16'h03e8, 1'b0}, '{5'h08, 8'h09, 16'h0348, 1'b0},
        '{5'h09, 8'h0e, 16'h02a8, 1'b0}, '{5'h0a, 8'h04, 16'h0208, 1'b0},
        '{5'h0b, 8'h09, 16'h015e, 1'b0}, '{5'h0c, 8'h0e, 16'h00c8, 1'b0},
        '{5'h0d, 8'h04, 16'h0064, 1'b1}, '{5'h0e, 8'h09, 16'h0032, 1'b1},
        '{5'h0f, 8'h0e, 16'h000a, 1'b1}, '{5'h10, 8'h04, 16'h0005, 1'b1}
    };

    logic          clock;
    logic          rst_n;
    logic          enableSet;
    logic          regulatorEnable;
    logic          overTemp;
    logic [3:0]    sinkNearDropout;
    logic [3:0]    sinkOpen;
    logic [3:0]    sinkBelowThreshold;
    logic          pumpEnable;
    plcc_pump_type pumpMode;
    logic          pumpClockEn;
    logic [3:0]    sinkEnable;
    logic [3:0]    sinkTestCurrent;
    logic [15:0]   sinkCurrentUa;
    logic          lowQuiescent;
    logic          regulatorOn;
    logic [4:0]    activeCode;
    int            mismatches = 0;
    int            nCompared = 0;
    int            pulses;

    plcc_host_model host (
        .clock (clock),
        .line  (enableSet)
    );

    plcc_ctrl #(
        .LATCH_CYCLES   (LATCH),
        .OFF_CYCLES     (OFF),
        .STARTUP_CYCLES (START),
        .TEST_CYCLES    (TEST),
        .PUMP_DIV       (DIV),
        .CHANNELS       (4)
    ) uut (
        .clock              (clock),
        .rst_n              (rst_n),
        .enableSet          (enableSet),
        .regulatorEnable    (regulatorEnable),
        .overTemp           (overTemp),
        .sinkNearDropout    (sinkNearDropout),
        .sinkOpen           (sinkOpen),
        .sinkBelowThreshold (sinkBelowThreshold),
        .pumpEnable         (pumpEnable),
        .pumpMode           (pumpMode),
        .pumpClockEn        (pumpClockEn),
        .sinkEnable         (sinkEnable),
        .sinkTestCurrent    (sinkTestCurrent),
        .sinkCurrentUa      (sinkCurrentUa),
        .lowQuiescent       (lowQuiescent),
        .regulatorOn        (regulatorOn),
        .activeCode         (activeCode)
    );

    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        nCompared++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        $display("compared=%0d mismatches=%0d", nCompared, mismatches);
        if (mismatches == 0 && nCompared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic waitCyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    // Sync delay plus one output cycle fit inside the extra margin
    task automatic latchCode(input int n, input int half);
        host.sendCode(n, half);
        waitCyc(LATCH + 8);
    endtask

    initial begin
        rst_n = 1'b0;
        regulatorEnable = 1'b0;
        overTemp = 1'b0;
        sinkNearDropout = 4'h0;
        sinkOpen = 4'h0;
        sinkBelowThreshold = 4'hf;
        repeat (4) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        waitCyc(2);
        check(16'(activeCode), 16'h0000);
        check(16'(pumpEnable), 16'h0000);
        foreach (rows[i]) begin
            latchCode(int'(rows[i].code), int'(rows[i].half));
            check(16'(activeCode), 16'(rows[i].code));
            check(sinkCurrentUa, rows[i].cur);
            check(16'(lowQuiescent), 16'(rows[i].lowQ));
        end
        latchCode(3, 4);
        check(16'(activeCode), 16'h0003);
        // Overlong burst must stick at the top code, not wrap
        latchCode(20, 4);
        check(16'(activeCode), 16'h0010);
        waitCyc(START + TEST + 10);
        check(16'(pumpEnable), 16'h0001);
        check(16'(sinkEnable), 16'h000f);
        sinkNearDropout = 4'h2;
        waitCyc(8);
        check(16'(pumpMode), 16'(PUMP_1P5X));
        sinkNearDropout = 4'h0;
        waitCyc(8);
        sinkNearDropout = 4'h2;
        waitCyc(8);
        check(16'(pumpMode), 16'(PUMP_2X));
        pulses = 0;
        repeat (10 * DIV) begin
            @(negedge clock);
            pulses += int'(pumpClockEn);
        end
        check(16'(pulses), 16'h000a);
        sinkNearDropout = 4'h0;
        regulatorEnable = 1'b1;
        host.setLine(1'b0);
        waitCyc(OFF + 10);
        check(16'(activeCode), 16'h0000);
        check(16'(pumpEnable), 16'h0000);
        check(16'(sinkEnable), 16'h0000);
        check(16'(regulatorOn), 16'h0001);
        // Failed channels and an open sink on restart
        sinkBelowThreshold = 4'ha;
        sinkOpen = 4'h4;
        latchCode(5, 4);
        check(16'(activeCode), 16'h0005);
        waitCyc(START);
        check(16'(sinkTestCurrent), 16'h000f);
        waitCyc(TEST + 10);
        check(16'(sinkEnable), 16'h000a);
        check(16'(pumpMode), 16'(PUMP_2X));
        overTemp = 1'b1;
        waitCyc(8);
        check(16'(pumpEnable), 16'h0000);
        check(16'(regulatorOn), 16'h0000);
        check(16'(sinkEnable), 16'h0000);
        overTemp = 1'b0;
        waitCyc(START + TEST + 10);
        check(16'(pumpEnable), 16'h0001);
        check(16'(regulatorOn), 16'h0001);
        check(16'(activeCode), 16'h0005);
        complete_run();
    end

    // Whole run needs roughly 4000 cycles
    initial begin
        repeat (40000) @(posedge clock);
        mismatches++;
        $display("watchdog expired at t=%0t", $time);
        complete_run();
    end
endmodule
